// [pkg/mic_pkg.sv]
// Purpose: Constants, register map and types of the interrupt controller.
// Assumes: Registers sit on a 32-bit AXI4-Lite bus at four times their index.
// Notes: Summary of operation is listed below.
//
// Summary of operation
// R1: Eight sources: ext pin, tick0 overflow, pin change, comparator, A/D, tick1, tick2, capture/PWM.
// R2: A/D, tick2 match and capture/PWM exist only on the larger variant.
// R3: Every request is latched in its own flag bit.
// R4: Global enable set passes unmasked requests; clear blocks them all.
// R5: Each source has its own enable bit.
// R6: Reset clears the global enable.
// R7: Taking an interrupt clears global enable, core pushes return, loads vector 0004h.
// R8: Return from handler sets the global enable again.
// R9: Ext pin, pin change and tick0 flags and enables live in core control.
// R10: Peripheral flags in peripheral flag register, enables in peripheral enable register.
// R11: Latency from an external event to the vector is three or four cycles.
// R12: Software clears serviced flags before enabling again, else repeated requests.
// R13: Flags set whatever their enable or the global enable say.
// R14: Clearing global enable drops an imminent take; request stays pending.
// R15: Interrupt wake resumes at next address; vector follows if global enable set.
// R16: Interrupt wake sets time-out status and clears power-down status.
// R17: Interrupt wake is always caused by at least one enabled flag.
// R18: Ext pin flag on rising edge if edge select set, else falling edge.
// R19: Tick0 rolling from FFh to 00h sets the tick0 overflow flag.
// R20: Change on a pin enabled in the pin-change mask sets pin-change flag.
// R21: Request = global and (core hits or group enable and peripheral hits).
package mic_pkg;

   localparam int unsigned ADDR_W = 12;
   localparam int unsigned PIN_W = 6;
   localparam int unsigned PC_W = 13;

   // Register indices; byte address is four times the index
   localparam logic [7:0] STATUS_IDX = 8'h03;
   localparam logic [7:0] CORE_IDX = 8'h0B;
   localparam logic [7:0] PFLAG_IDX = 8'h0C;
   localparam logic [7:0] OPTION_IDX = 8'h81;
   localparam logic [7:0] PENABLE_IDX = 8'h8C;
   localparam logic [7:0] PCMASK_IDX = 8'h96;

   // Core control register fields
   localparam int unsigned GIE_BIT = 7;
   localparam int unsigned PERIPHERAL_GROUP_ENABLE_BIT = 6;
   localparam int unsigned TICK0_OVERFLOW_ENABLE_BIT = 5;
   localparam int unsigned EXTIE_BIT = 4;
   localparam int unsigned PCIE_BIT = 3;
   localparam int unsigned TICK0_OVERFLOW_FLAG_BIT = 2;
   localparam int unsigned EXTIF_BIT = 1;
   localparam int unsigned PCIF_BIT = 0;

   // Peripheral flag and enable fields
   localparam int unsigned ADC_BIT = 6;
   localparam int unsigned CCP_BIT = 5;
   localparam int unsigned CMP_BIT = 3;
   localparam int unsigned TK2_BIT = 1;
   localparam int unsigned TK1_BIT = 0;
   localparam logic [7:0] PERIPH_MASK_LARGE = 8'h6B;
   localparam logic [7:0] PERIPH_MASK_SMALL = 8'h09;
   localparam logic [7:0] PCMASK_MASK = 8'h3F;

   // Option and status fields
   localparam int unsigned EDGE_SEL_BIT = 6;
   localparam int unsigned TO_BIT = 4;
   localparam int unsigned PD_BIT = 3;

   // Reset values
   localparam logic [7:0] CORE_RST = 8'h00;
   localparam logic [7:0] PFLAG_RST = 8'h00;
   localparam logic [7:0] PENABLE_RST = 8'h00;
   localparam logic [7:0] PCMASK_RST = 8'h00;
   localparam logic EDGE_SEL_RST = 1'b1;
   localparam logic TO_RST = 1'b1;
   localparam logic PD_RST = 1'b1;

   localparam logic [7:0] TICK_MAX = 8'hFF;
   localparam logic [7:0] TICK_ZERO = 8'h00;
   localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;

   // Instruction strobes from arming to take, minus one
   localparam logic [1:0] LAT_STROBES = 2'h1;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_ARMED = 3'b010,
      ST_SLEEP = 3'b100
   } mic_state_t;

endpackage : mic_pkg

// [rtl/mic_edge.sv]
// Purpose: Per-bit rising and falling edge detection of sampled inputs.
// Assumes: Inputs are synchronous to aclk.
// Notes: The first sample after reset only primes the history.
`timescale 1ns/1ps
module mic_edge #(
   parameter int unsigned W = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [W-1:0] din,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] prev_reg;
   logic primed_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_reg <= '0;
         primed_reg <= 1'b0;
      end else if (ce) begin
         prev_reg <= din;
         primed_reg <= 1'b1;
      end
   end

   assign rise = primed_reg ? (din & ~prev_reg) : '0;
   assign fall = primed_reg ? (~din & prev_reg) : '0;
endmodule : mic_edge

// [rtl/mic_top.sv]
// Purpose: Interrupt controller with flags, enables, vectoring and sleep wake-up.
// Assumes: instr_strobe pulses once per instruction cycle; events are synchronous.
// Notes: The core pushes the return address when irq_take pulses.
`timescale 1ns/1ps
module mic_top
   import mic_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [mic_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [mic_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_irq_pin,
   input wire logic [7:0] tick0_count,
   input wire logic [mic_pkg::PIN_W-1:0] pin_in,
   input wire logic cmp_event,
   input wire logic adc_done,
   input wire logic tick1_overflow,
   input wire logic tick2_match,
   input wire logic ccp_event,
   input wire logic instr_strobe,
   input wire logic sleep_enter,
   input wire logic return_from_handler,
   output logic irq_take,
   output logic [mic_pkg::PC_W-1:0] irq_vector,
   output logic irq_request,
   output logic wake_event,
   output logic sleeping
);
   import mic_pkg::*;

   localparam logic [7:0] PERIPH_MASK = LARGE_VARIANT ? PERIPH_MASK_LARGE : PERIPH_MASK_SMALL; // R2

   logic [7:0] core_irq_control_reg;
   logic [7:0] core_irq_control_next;
   logic [7:0] peripheral_flag_reg;
   logic [7:0] peripheral_flag_next;
   logic [7:0] peripheral_enable_reg;
   logic [7:0] pin_change_enable_mask_reg;
   logic ext_edge_select_reg;
   logic timeout_status_bit_reg;
   logic powerdown_status_bit_reg;
   logic [7:0] tick0_prev_reg;
   logic tick0_primed_reg;

   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [7:0] wdata_reg;
   logic wstrb0_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;

   mic_state_t state_reg;
   logic [1:0] lat_cnt_reg;
   logic irq_take_reg;
   logic irq_request_reg;
   logic wake_reg;
   logic sleeping_reg;
   logic [PC_W-1:0] vector_reg;

   logic ext_rise;
   logic ext_fall;
   logic [PIN_W-1:0] pin_rise;
   logic [PIN_W-1:0] pin_fall;
   logic ext_evt;
   logic pc_evt;
   logic t0_evt;
   logic [7:0] periph_evt;
   logic core_hit;
   logic periph_hit;
   logic req_any;
   logic request;
   logic take_fire;
   logic wake_fire;
   logic wr_commit;
   logic [7:0] wr_idx;
   logic wr_ok;
   logic [7:0] rd_idx;
   logic rd_ok;
   logic [7:0] rd_byte;

   mic_edge #(.W(1)) u_ext_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .din(ext_irq_pin),
      .rise(ext_rise),
      .fall(ext_fall)
   );

   mic_edge #(.W(PIN_W)) u_pin_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .din(pin_in),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Event detection
   assign ext_evt = ext_edge_select_reg ? ext_rise : ext_fall; // R18
   assign pc_evt = |((pin_rise | pin_fall) & pin_change_enable_mask_reg[PIN_W-1:0]); // R20
   assign t0_evt = tick0_primed_reg && (tick0_prev_reg == TICK_MAX)
                   && (tick0_count == TICK_ZERO); // R19

   always_comb begin
      periph_evt = 8'h00;
      periph_evt[ADC_BIT] = adc_done;
      periph_evt[CCP_BIT] = ccp_event;
      periph_evt[CMP_BIT] = cmp_event;
      periph_evt[TK2_BIT] = tick2_match;
      periph_evt[TK1_BIT] = tick1_overflow; // R1
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick0_prev_reg <= TICK_ZERO;
         tick0_primed_reg <= 1'b0;
      end else if (ce) begin
         tick0_prev_reg <= tick0_count;
         tick0_primed_reg <= 1'b1;
      end
   end

   // Request combination
   assign core_hit = (core_irq_control_reg[TICK0_OVERFLOW_FLAG_BIT] & core_irq_control_reg[TICK0_OVERFLOW_ENABLE_BIT])
                   | (core_irq_control_reg[EXTIF_BIT] & core_irq_control_reg[EXTIE_BIT])
                   | (core_irq_control_reg[PCIF_BIT] & core_irq_control_reg[PCIE_BIT]); // R5
   assign periph_hit = |(peripheral_flag_reg & peripheral_enable_reg & PERIPH_MASK); // R5
   assign req_any = core_hit | (core_irq_control_reg[PERIPHERAL_GROUP_ENABLE_BIT] & periph_hit); // R21
   assign request = core_irq_control_reg[GIE_BIT] & req_any; // R4

   assign take_fire = ce && (state_reg == ST_ARMED) && instr_strobe && request
                      && (lat_cnt_reg == 2'h0); // R11
   assign wake_fire = ce && (state_reg == ST_SLEEP) && req_any; // R17

   // Register bus decode
   assign wr_idx = awaddr_reg[9:2];
   assign wr_ok = (awaddr_reg[1:0] == 2'b00) && (awaddr_reg[ADDR_W-1:10] == '0)
                  && (wr_idx == STATUS_IDX || wr_idx == CORE_IDX || wr_idx == PFLAG_IDX
                   || wr_idx == OPTION_IDX || wr_idx == PENABLE_IDX || wr_idx == PCMASK_IDX);
   assign wr_commit = ce && !awready_reg && !wready_reg && !bvalid_reg;
   assign rd_idx = s_axi_araddr[9:2];

   always_comb begin
      rd_ok = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr[ADDR_W-1:10] == '0);
      rd_byte = 8'h00;
      unique case (rd_idx)
         STATUS_IDX: begin
            rd_byte[TO_BIT] = timeout_status_bit_reg;
            rd_byte[PD_BIT] = powerdown_status_bit_reg;
         end
         CORE_IDX: rd_byte = core_irq_control_reg;
         PFLAG_IDX: rd_byte = peripheral_flag_reg;
         OPTION_IDX: rd_byte[EDGE_SEL_BIT] = ext_edge_select_reg;
         PENABLE_IDX: rd_byte = peripheral_enable_reg;
         PCMASK_IDX: rd_byte = pin_change_enable_mask_reg;
         default: rd_ok = 1'b0;
      endcase
   end

   // Write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         awaddr_reg <= '0;
         wdata_reg <= 8'h00;
         wstrb0_reg <= 1'b0;
      end else if (ce) begin
         if (awready_reg && s_axi_awvalid) begin
            awready_reg <= 1'b0;
            awaddr_reg <= s_axi_awaddr;
         end
         if (wready_reg && s_axi_wvalid) begin
            wready_reg <= 1'b0;
            wdata_reg <= s_axi_wdata[7:0];
            wstrb0_reg <= s_axi_wstrb[0];
         end
         if (wr_commit) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else if (ce) begin
         if (arready_reg && s_axi_arvalid) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            rdata_reg <= rd_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // Core control: events set flags over a simultaneous clearing write
   always_comb begin
      core_irq_control_next = core_irq_control_reg;
      if (wr_commit && wr_ok && wstrb0_reg && wr_idx == CORE_IDX) begin
         core_irq_control_next = wdata_reg;
      end
      if (return_from_handler) begin
         core_irq_control_next[GIE_BIT] = 1'b1; // R8
      end
      if (take_fire) begin
         core_irq_control_next[GIE_BIT] = 1'b0; // R7
      end
      core_irq_control_next[TICK0_OVERFLOW_FLAG_BIT] = core_irq_control_next[TICK0_OVERFLOW_FLAG_BIT] | t0_evt; // R9 R13
      core_irq_control_next[EXTIF_BIT] = core_irq_control_next[EXTIF_BIT] | ext_evt; // R9 R13
      core_irq_control_next[PCIF_BIT] = core_irq_control_next[PCIF_BIT] | pc_evt; // R9 R13
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_irq_control_reg <= CORE_RST; // R6
      end else if (ce) begin
         core_irq_control_reg <= core_irq_control_next; // R3
      end
   end

   // Peripheral flags and enables
   always_comb begin
      peripheral_flag_next = peripheral_flag_reg;
      if (wr_commit && wr_ok && wstrb0_reg && wr_idx == PFLAG_IDX) begin
         peripheral_flag_next = wdata_reg;
      end
      peripheral_flag_next = (peripheral_flag_next | periph_evt) & PERIPH_MASK; // R10 R13
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         peripheral_flag_reg <= PFLAG_RST;
      end else if (ce) begin
         peripheral_flag_reg <= peripheral_flag_next; // R3
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         peripheral_enable_reg <= PENABLE_RST;
         pin_change_enable_mask_reg <= PCMASK_RST;
         ext_edge_select_reg <= EDGE_SEL_RST;
      end else if (wr_commit && wr_ok && wstrb0_reg) begin
         if (wr_idx == PENABLE_IDX) begin
            peripheral_enable_reg <= wdata_reg & PERIPH_MASK; // R10
         end
         if (wr_idx == PCMASK_IDX) begin
            pin_change_enable_mask_reg <= wdata_reg & PCMASK_MASK; // R20
         end
         if (wr_idx == OPTION_IDX) begin
            ext_edge_select_reg <= wdata_reg[EDGE_SEL_BIT]; // R18
         end
      end
   end

   // Power status bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timeout_status_bit_reg <= TO_RST;
         powerdown_status_bit_reg <= PD_RST;
      end else if (ce) begin
         if (wake_fire || (state_reg == ST_RUN && sleep_enter)) begin
            timeout_status_bit_reg <= 1'b1; // R16
            powerdown_status_bit_reg <= 1'b0; // R16
         end
      end
   end

   // Take sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_RUN;
         lat_cnt_reg <= 2'h0;
      end else if (ce) begin
         unique case (state_reg)
            ST_RUN: begin
               if (sleep_enter) begin
                  state_reg <= ST_SLEEP;
               end else if (instr_strobe && request) begin
                  state_reg <= ST_ARMED; // R11
                  lat_cnt_reg <= LAT_STROBES;
               end
            end
            ST_ARMED: begin
               if (instr_strobe) begin
                  if (!request || lat_cnt_reg == 2'h0) begin
                     state_reg <= ST_RUN; // R14
                  end else begin
                     lat_cnt_reg <= lat_cnt_reg - 2'h1;
                  end
               end
            end
            ST_SLEEP: begin
               if (req_any) begin
                  state_reg <= ST_RUN; // R15
               end
            end
         endcase
      end
   end

   // Core-facing outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_take_reg <= 1'b0;
         irq_request_reg <= 1'b0;
         wake_reg <= 1'b0;
         sleeping_reg <= 1'b0;
         vector_reg <= VECTOR_ADDR;
      end else if (ce) begin
         irq_take_reg <= take_fire; // R7
         irq_request_reg <= request;
         wake_reg <= wake_fire; // R15
         sleeping_reg <= (state_reg == ST_SLEEP) ? !req_any : (state_reg == ST_RUN && sleep_enter);
         vector_reg <= VECTOR_ADDR; // R7
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign irq_take = irq_take_reg;
   assign irq_vector = vector_reg;
   assign irq_request = irq_request_reg;
   assign wake_event = wake_reg;
   assign sleeping = sleeping_reg;
endmodule : mic_top

// [tb/mic_props.sv]
// Purpose: Port-level checks of the interrupt controller.
// Assumes: One clock domain, synchronous reset active low.
// Notes: Bound to mic_top at the foot of this file.
`timescale 1ns/1ps
module mic_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic instr_strobe,
   input wire logic sleep_enter,
   input wire logic irq_take,
   input wire logic [mic_pkg::PC_W-1:0] irq_vector,
   input wire logic irq_request,
   input wire logic wake_event,
   input wire logic sleeping
);
   import mic_pkg::*;
   logic [2:0] strobe_cnt;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Strobes seen while a request waits
   always_ff @(posedge aclk) begin
      if (!aresetn || !irq_request || irq_take || sleeping) begin
         strobe_cnt <= 3'h0;
      end else if (ce && instr_strobe && strobe_cnt != 3'h7) begin
         strobe_cnt <= strobe_cnt + 3'h1;
      end
   end

   sequence s_take_done;
      irq_take ##1 (!irq_take && !irq_request);
   endsequence
   sequence s_wake_done;
      (wake_event && !sleeping) ##1 !wake_event;
   endsequence

   a_take_needs_req: assert property (irq_take |-> $past(irq_request) && $past(instr_strobe))
      else $error("Take without a prior request and strobe");
   a_take_clears_gie: assert property (irq_take |-> s_take_done)
      else $error("Request still up after a take");
   a_take_in_time: assert property (strobe_cnt <= 3'h3)
      else $error("Take later than three strobes");
   a_vector_fixed: assert property (irq_vector == VECTOR_ADDR)
      else $error("Vector address wrong");
   a_reset_quiet: assert property (disable iff (1'h0) !aresetn |=>
      !irq_take && !irq_request && !wake_event && !sleeping)
      else $error("Outputs active after reset");
   a_sleep_entry: assert property (sleep_enter && ce && !sleeping && !irq_request |=> sleeping)
      else $error("Sleep not entered");
   a_wake_from_sleep: assert property (wake_event |-> $past(sleeping) ##0 s_wake_done)
      else $error("Wake pulse outside sleep");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data dropped");
   a_read_answer: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready))
      else $error("Read data without address");
endmodule : mic_props

bind mic_top mic_props i_props (.*);

// [tb/mic_core_model.sv]
// Purpose: Behavioural core sequencer facing the interrupt controller.
// Assumes: One instruction cycle lasts four aclk cycles.
// Notes: Pushes the return address on a take, pops it on return.
`timescale 1ns/1ps
module mic_core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic irq_take,
   input wire logic [mic_pkg::PC_W-1:0] irq_vector,
   input wire logic return_from_handler,
   output logic instr_strobe,
   output logic [mic_pkg::PC_W-1:0] pc_reg,
   output logic [3:0] depth_reg
);
   import mic_pkg::*;
   logic [1:0] phase_reg;
   logic [mic_pkg::PC_W-1:0] stack_mem [0:7];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_reg <= 2'h0;
      end else begin
         phase_reg <= phase_reg + 2'h1;
      end
   end
   assign instr_strobe = (phase_reg == 2'h3);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_reg <= '0;
         depth_reg <= 4'h0;
      end else if (irq_take) begin
         stack_mem[depth_reg[2:0]] <= pc_reg;
         pc_reg <= irq_vector;
         depth_reg <= depth_reg + 4'h1;
      end else if (return_from_handler && depth_reg != 4'h0) begin
         pc_reg <= stack_mem[depth_reg[2:0] - 3'h1];
         depth_reg <= depth_reg - 4'h1;
      end else if (instr_strobe) begin
         pc_reg <= pc_reg + 13'h0001;
      end
   end
endmodule : mic_core_model

// [tb/mcu_interrupt_controller_tb_top.sv]
// Purpose: Self-checking bench of the interrupt controller.
// Assumes: Core model strobes every four cycles.
// Notes: Register byte address is four times its index.
`timescale 1ns/1ps
module mcu_interrupt_controller_tb_top;
   import mic_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic ce = 1'h1;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic ext_irq_pin = 1'h0, cmp_event = 1'h0, adc_done = 1'h0, tick1_overflow = 1'h0;
   logic tick2_match = 1'h0, ccp_event = 1'h0, sleep_enter = 1'h0, return_from_handler = 1'h0;
   logic [7:0] tick0_count = 8'h00;
   logic [PIN_W-1:0] pin_in = '0;
   logic instr_strobe, irq_take, irq_request, wake_event, sleeping;
   logic [PC_W-1:0] irq_vector, pc_reg;
   logic [3:0] depth_reg;
   int failures = 0, checked = 0, takes = 0, wakes = 0, cycles = 0;

   mic_top #(.LARGE_VARIANT(1'h1)) i_dut (
      .*, .s_axi_awprot(3'h0), .s_axi_wstrb(4'hF), .s_axi_arprot(3'h0)
   );
   mic_core_model i_core (.*);

   always #5 aclk = ~aclk;

   always @(posedge aclk) begin
      cycles++;
      if (irq_take === 1'h1) takes++;
      if (wake_event === 1'h1) wakes++;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got 0x%h expected 0x%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= {2'h0, idx, 2'h0};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'h0;
      chk({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
      input logic [1:0] er = RESP_OKAY);
      @(posedge aclk);
      s_axi_araddr <= {2'h0, idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, {24'h000000, exp});
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask : rd

   // Bits: sleep, return, capture, converter, tick2, tick1, comparator
   task automatic pulse_ev(input logic [6:0] m);
      @(posedge aclk);
      {sleep_enter, return_from_handler, ccp_event, adc_done, tick2_match, tick1_overflow,
         cmp_event} <= m;
      @(posedge aclk);
      {sleep_enter, return_from_handler, ccp_event, adc_done, tick2_match, tick1_overflow,
         cmp_event} <= 7'h00;
   endtask : pulse_ev

   task automatic rise_ext();
      @(posedge aclk);
      ext_irq_pin <= 1'h0;
      @(posedge aclk);
      ext_irq_pin <= 1'h1;
   endtask : rise_ext

   task automatic wait_take(output int n);
      n = 0;
      for (int i = 0; i < 200; i++) begin
         @(posedge aclk);
         if (irq_take === 1'h1) return;
         if (instr_strobe === 1'h1) n++;
      end
      n = -1;
   endtask : wait_take

   task automatic t_reset_values();
      rd(CORE_IDX, CORE_RST);
      rd(PFLAG_IDX, PFLAG_RST);
      rd(PENABLE_IDX, PENABLE_RST);
      rd(PCMASK_IDX, PCMASK_RST);
      rd(OPTION_IDX, {1'h0, EDGE_SEL_RST, 6'h00});
      rd(STATUS_IDX, {3'h0, TO_RST, PD_RST, 3'h0});
      rd(8'h05, 8'h00, RESP_SLVERR);
      wr(PENABLE_IDX, 8'hFF);
      rd(PENABLE_IDX, PERIPH_MASK_LARGE);
      wr(PENABLE_IDX, 8'h00);
   endtask : t_reset_values

   task automatic t_flags();
      wr(PCMASK_IDX, 8'h04);
      rise_ext();
      @(posedge aclk);
      tick0_count <= TICK_MAX;
      @(posedge aclk);
      tick0_count <= TICK_ZERO;
      @(posedge aclk);
      pin_in <= 6'h01;
      rd(CORE_IDX, 8'h06);
      pin_in <= 6'h05;
      rd(CORE_IDX, 8'h07);
      pulse_ev(7'h1F);
      rd(PFLAG_IDX, PERIPH_MASK_LARGE);
      chk({31'h0, irq_request}, 32'h0);
      wr(CORE_IDX, 8'h00);
      wr(OPTION_IDX, 8'h00);
      rise_ext();
      rd(CORE_IDX, 8'h02);
      wr(OPTION_IDX, 8'h40);
      wr(CORE_IDX, 8'h00);
      wr(PFLAG_IDX, 8'h00);
      rd(PFLAG_IDX, 8'h00);
   endtask : t_flags

   task automatic t_take();
      int n;
      wr(CORE_IDX, 8'h90);
      rise_ext();
      wait_take(n);
      chk({31'h0, n >= 3 && n <= 4}, 32'h1);
      @(posedge aclk);
      chk({19'h0, pc_reg}, {19'h0, VECTOR_ADDR});
      chk({28'h0, depth_reg}, 32'h1);
      rd(CORE_IDX, 8'h12);
      wr(CORE_IDX, 8'h10);
      pulse_ev(7'h20);
      rd(CORE_IDX, 8'h90);
      chk({28'h0, depth_reg}, 32'h0);
   endtask : t_take

   task automatic t_group();
      int n, t0;
      wr(PENABLE_IDX, 8'h08);
      t0 = takes;
      pulse_ev(7'h01);
      repeat (40) @(posedge aclk);
      chk(takes - t0, 0);
      wr(CORE_IDX, 8'hD0);
      wait_take(n);
      chk({31'h0, n >= 0}, 32'h1);
      rd(CORE_IDX, 8'h50);
      wr(PFLAG_IDX, 8'h00);
      wr(PENABLE_IDX, 8'h00);
      wr(CORE_IDX, 8'h00);
   endtask : t_group

   task automatic t_gie_drop();
      int n, t0;
      wr(CORE_IDX, 8'h10);
      rise_ext();
      wr(CORE_IDX, 8'h92);
      while (instr_strobe !== 1'h1) @(posedge aclk);
      t0 = takes;
      wr(CORE_IDX, 8'h12);
      repeat (40) @(posedge aclk);
      chk(takes - t0, 0);
      rd(CORE_IDX, 8'h12);
      wr(CORE_IDX, 8'h92);
      wait_take(n);
      chk({31'h0, n >= 0}, 32'h1);
      wr(CORE_IDX, 8'h00);
   endtask : t_gie_drop

   task automatic t_sleep();
      int t0, w0;
      for (int g = 0; g < 2; g++) begin
         wr(CORE_IDX, {g[0], 7'h10});
         pulse_ev(7'h40);
         @(posedge aclk);
         chk({31'h0, sleeping}, 32'h1);
         t0 = takes;
         w0 = wakes;
         rise_ext();
         repeat (30) @(posedge aclk);
         chk(wakes - w0, 1);
         chk(takes - t0, g);
         chk({31'h0, sleeping}, 32'h0);
         rd(STATUS_IDX, 8'h10);
         rd(CORE_IDX, 8'h12);
         wr(CORE_IDX, 8'h00);
      end
   endtask : t_sleep

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset_values();
      t_flags();
      t_take();
      t_group();
      t_gie_drop();
      t_sleep();
      finish_test();
   end
endmodule : mcu_interrupt_controller_tb_top
